// ---- logic/ssl_params.svh ----
// timing counts and reset values for the supply state lockout control
`ifndef SSL_PARAMS_SVH
`define SSL_PARAMS_SVH
`define SSL_CLK_MHZ 250
`define SSL_READY_MIN_US 250
`define SSL_READY_MAX_US 450
`define SSL_FUSE_US 50
// fuse read is a least time: round up
`define SSL_FUSE_CYC ((`SSL_FUSE_US * `SSL_CLK_MHZ * 1000 + 999) / 1000)
// total ready time aims at the minimum bound, rounded up, to stay under max
`define SSL_READY_CYC ((`SSL_READY_MIN_US * `SSL_CLK_MHZ * 1000 + 999) / 1000)
`define SSL_READY_MAX_CYC (`SSL_READY_MAX_US * `SSL_CLK_MHZ)
`define SSL_WORD_BITS 24
`define SSL_CFG_RST 5'h00
`define SSL_CURLIM_CODE 3'h0
`endif

// ---- logic/ssl_pkg.sv ----
// types for the supply state lockout control
package ssl_pkg;
    typedef enum logic [1:0] {
        SSL_RESET = 2'b00,
        SSL_LOCK = 2'b01,
        SSL_FUSE = 2'b11,
        SSL_NORMAL = 2'b10
    } ssl_state_t;

    typedef struct packed {
        logic por;
        logic uv;
        logic ov;
        logic low_batt;
        logic double_batt;
        logic io_ok;
    } ssl_supply_t;

    typedef struct packed {
        logic [2:0] current_code;
        logic por_seen;
        logic uv_seen;
    } ssl_cfg_t;
endpackage

// ---- logic/ssl_sync.sv ----
// two-stage synchroniser for comparator levels
module ssl_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // sync reset, active low
    input wire logic [W-1:0] d_i, // asynchronous levels
    output logic [W-1:0] q_o // synchronised levels
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    // reset level chosen by the user so no false release leaks out
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule

// ---- logic/ssl_core.sv ----
// supply state lockout control: reset, lockout, fuse read and serial gating
// Behaviour
// - in undervoltage lockout the serial data output is high impedance
// - in lockout every select assertion is ignored, no transfer or write
// - lockout during a word locks out, then discards the partial word
// - lockout latches an undervoltage-seen bit, readable after recovery
// - power-on reset returns registers to defaults and disables serial port
// - after reset release, set reset-occurred flag in configuration register
// - overvoltage forces limited current setting, keeps and restores setup
// - double battery range operates normally and sets no fault
// - low battery band keeps serial port working with true status
// - interrupt output held low from reset until device is ready
// - without io supply logic runs but drives no pins, resumes later; only miso is released here, int_n_o stays driven
// - losing io supply keeps state and registers, resumes on return
// - ready interval from reset or lockout lies within 250 to 450 us
// - fuse read phase of at least 50 us precedes normal operation
`include "ssl_params.svh"
module ssl_core
    import ssl_pkg::*;
(
    input wire logic clk_sys_i, // system clock, 250 MHz
    input wire logic rstn_i, // sync reset, active low
    input ssl_pkg::ssl_supply_t supply_i, // supply comparator levels
    input wire logic sel_n_i, // serial select, active low
    input wire logic sck_rise_i, // serial clock rising, one-cycle pulse
    input wire logic mosi_i, // serial data in
    input wire logic event_int_i, // interrupt request from switch logic
    output logic miso_o, // serial data out
    output logic miso_oe_n_o, // serial out enable, low drives
    output logic int_n_o, // interrupt output level, active low
    output logic ready_o, // device in normal operation
    output ssl_pkg::ssl_cfg_t cfg_o, // configuration register content
    output logic [2:0] current_o, // effective current source code
    output logic word_o, // one-cycle pulse: word accepted
    output logic [`SSL_WORD_BITS-1:0] word_data_o // accepted word
);
    import ssl_pkg::*;

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    //--------------------------------------------------
    // synchronised comparators
    //--------------------------------------------------
    logic [2:0] cmp;
    logic por_s;
    logic uv_s;
    logic ov_s;

    // por and uv read as asserted until real levels arrive
    ssl_sync #(.W(3), .RST_VAL(3'b110)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i({supply_i.por, supply_i.uv, supply_i.ov}),
        .q_o(cmp)
    );
    assign por_s = cmp[2];
    assign uv_s = cmp[1];
    assign ov_s = cmp[0];

    //--------------------------------------------------
    // power state machine
    //--------------------------------------------------
    ssl_state_t state;
    ssl_state_t next_state;
    logic [17:0] tmr;
    logic [17:0] next_tmr;
    ssl_cfg_t cfg;
    ssl_cfg_t next_cfg;
    logic por_pend;
    logic next_por_pend;
    logic [`SSL_WORD_BITS-1:0] word_data;
    logic [`SSL_WORD_BITS-1:0] next_word_data;

    function automatic logic [17:0] cyc(input int n);
        return 18'(n);
    endfunction

    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_cfg = cfg;
        next_por_pend = por_pend;
        if (por_s) begin
            // reset beats lockout; registers back to defaults
            next_state = SSL_RESET;
            next_cfg = ssl_cfg_t'(`SSL_CFG_RST);
            next_por_pend = 1'b1;
            next_tmr = '0;
        end else begin
            unique case (state)
                SSL_RESET: begin
                    next_state = SSL_LOCK;
                    next_tmr = '0;
                end
                SSL_LOCK: begin
                    if (!uv_s) begin
                        next_state = SSL_FUSE;
                        next_tmr = '0;
                    end
                end
                SSL_FUSE: begin
                    next_tmr = tmr + 18'h1;
                    if (uv_s) begin
                        next_state = SSL_LOCK;
                    end else if (tmr >= cyc(`SSL_READY_CYC) - 18'h1) begin
                        // fuse read done, ready window honoured
                        next_state = SSL_NORMAL;
                        if (por_pend) begin
                            next_cfg.por_seen = 1'b1;
                        end
                        next_por_pend = 1'b0;
                    end
                end
                SSL_NORMAL: begin
                    // low and double battery do not leave normal
                    if (uv_s) begin
                        next_state = SSL_LOCK;
                    end
                end
            endcase
            if (uv_s) begin
                next_cfg.uv_seen = 1'b1;
            end
            if (state == SSL_NORMAL && word_o && word_data[23]) begin
                // write word: bit 23 set, bits 22:20 program current, bits
                // 1:0 write one to clear status flags; set wins above
                next_cfg.current_code = word_data[22:20];
                if (word_data[1] && !uv_s) begin
                    next_cfg.uv_seen = 1'b0;
                end
                if (word_data[0]) begin
                    next_cfg.por_seen = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state <= SSL_RESET;
            tmr <= '0;
            cfg <= ssl_cfg_t'(`SSL_CFG_RST);
            por_pend <= 1'b1;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            cfg <= next_cfg;
            por_pend <= next_por_pend;
        end
    end

    //--------------------------------------------------
    // serial word shifter
    //--------------------------------------------------
    logic link_ok;
    logic [`SSL_WORD_BITS-1:0] shreg;
    logic [`SSL_WORD_BITS-1:0] next_shreg;
    logic [4:0] bits;
    logic [4:0] next_bits;
    logic active;
    logic next_active;
    logic word;
    logic next_word;
    logic miso;
    logic next_miso;

    // serial port usable only in normal with io supply
    assign link_ok = (state == SSL_NORMAL) && supply_i.io_ok;

    always_comb begin
        next_shreg = shreg;
        next_bits = bits;
        next_active = active;
        next_word_data = word_data;
        next_word = 1'b0;
        next_miso = miso;
        if (!link_ok) begin
            // partial word dropped, select ignored
            next_active = 1'b0;
            next_bits = '0;
        end else if (!sel_n_i) begin
            if (!active) begin
                next_active = 1'b1;
                next_bits = '0;
                next_shreg = {cfg, {(`SSL_WORD_BITS-5){1'b0}}};
                next_miso = cfg.current_code[2];
            end else if (sck_rise_i && bits != 5'(`SSL_WORD_BITS)) begin
                next_shreg = {shreg[`SSL_WORD_BITS-2:0], mosi_i};
                next_miso = shreg[`SSL_WORD_BITS-2];
                next_bits = bits + 5'h1;
            end
        end else if (active) begin
            next_active = 1'b0;
            if (bits == 5'(`SSL_WORD_BITS)) begin
                next_word = 1'b1;
                next_word_data = shreg;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            shreg <= '0;
            bits <= '0;
            active <= 1'b0;
            word_data <= '0;
            word <= 1'b0;
            miso <= 1'b0;
        end else begin
            shreg <= next_shreg;
            bits <= next_bits;
            active <= next_active;
            word_data <= next_word_data;
            word <= next_word;
            miso <= next_miso;
        end
    end

    //--------------------------------------------------
    // outputs
    //--------------------------------------------------
    assign word_o = word;
    assign word_data_o = word_data;
    assign miso_o = miso;
    assign miso_oe_n_o = !(link_ok && active);
    assign int_n_o = (state == SSL_NORMAL) ? !event_int_i : 1'b0;
    assign ready_o = (state == SSL_NORMAL);
    assign cfg_o = cfg;
    // overvoltage limits sources, stored setup untouched
    assign current_o = ov_s ? `SSL_CURLIM_CODE : cfg.current_code;

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    // cycles spent in the present fuse phase, held one cycle after it ends, zero elsewhere
    logic [18:0] rdy_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || state != SSL_FUSE) begin
            rdy_cnt <= '0;
        end else begin
            rdy_cnt <= rdy_cnt + 19'h1;
        end
    end

    a_miso_lock_off: assert property (
        uv_s |=> miso_oe_n_o)
        else $error("miso driven in lockout");
    a_no_word_lock: assert property (
        (state != SSL_NORMAL) |=> !word_o)
        else $error("word in lockout");
    a_drop_partial: assert property (
        (active && !link_ok) |=> !active ##1 !word_o)
        else $error("partial word kept");
    a_uv_latched: assert property (
        (uv_s && !por_s) |=> cfg.uv_seen)
        else $error("uv not latched");
    a_por_default: assert property (
        por_s |=> (cfg == ssl_cfg_t'(`SSL_CFG_RST)) && state == SSL_RESET)
        else $error("por did not clear");
    a_int_low: assert property (
        !ready_o |-> !int_n_o)
        else $error("int high before ready");
    a_ov_limit: assert property (
        ov_s |-> current_o == `SSL_CURLIM_CODE)
        else $error("ov no limit");
    a_ready_bound: assert property (
        rdy_cnt <= 19'(`SSL_READY_MAX_CYC))
        else $error("ready too late");
    a_fuse_min: assert property (
        (ready_o && $past(state) == SSL_FUSE) |->
        $past(rdy_cnt) >= 19'(`SSL_FUSE_CYC - 1))
        else $error("fuse phase short");
    a_batt_normal: assert property (
        (ready_o && !uv_s && !por_s &&
        (supply_i.low_batt || supply_i.double_batt)) |=> ready_o)
        else $error("battery band left normal");
endmodule

// ---- testbench/ssl_host.sv ----
// host serial model: select, clock rise pulses and data, msb first
module ssl_host (
    input wire logic clk_sys_i, // system clock
    input wire logic miso_i, // serial data from device
    output logic sel_n_o, // select, active low
    output logic sck_o, // serial clock rise pulse
    output logic mosi_o // serial data to device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] rx;
    initial begin
        sel_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        rx = 24'h0;
    end
    // one word: 24 pulses with a gap cycle, data flips between pulses
    task automatic send(input logic [23:0] w);
        @(negedge clk_sys_i) sel_n_o = 1'b0;
        @(negedge clk_sys_i);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk_sys_i);
            rx[i] = miso_i;
            mosi_o = w[i];
            sck_o = 1'b1;
            @(negedge clk_sys_i);
            sck_o = 1'b0;
            mosi_o = ~w[i];
        end
        @(negedge clk_sys_i) sel_n_o = 1'b1;
        repeat (3) @(negedge clk_sys_i);
    endtask
endmodule

// ---- testbench/tb.sv ----
// testbench for the supply state lockout control
`include "ssl_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssl_pkg::*;
    logic clk_sys, rstn, ev, miso, miso_oe_n, int_n, ready, word, bad;
    logic sel_n, sck, mosi;
    logic [2:0] cur, code;
    logic [23:0] wdata, w;
    ssl_supply_t sup;
    ssl_cfg_t cfg;
    int fail_count = 0;
    int samples_checked = 0;
    int nwords = 0;
    int n, n0;
    ssl_core dut (.clk_sys_i(clk_sys), .rstn_i(rstn), .supply_i(sup),
        .sel_n_i(sel_n), .sck_rise_i(sck), .mosi_i(mosi),
        .event_int_i(ev), .miso_o(miso),
        .miso_oe_n_o(miso_oe_n), .int_n_o(int_n), .ready_o(ready),
        .cfg_o(cfg), .current_o(cur), .word_o(word), .word_data_o(wdata));
    ssl_host host (.clk_sys_i(clk_sys), .miso_i(miso), .sel_n_o(sel_n),
        .sck_o(sck), .mosi_o(mosi));
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (word === 1'b1) nwords++;
    // ------------------------------------------------------------
    // checking and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    // configuration word as the host should read it back
    function automatic logic [31:0] exp_cfg(input logic [2:0] c,
        input logic por_seen, input logic uv_seen);
        return {27'h0, c, por_seen, uv_seen};
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    initial begin
        // the ready wait dominates the run
        #((`SSL_READY_CYC + 10000) * 4);
        fail_count++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        ev = 1'b0;
        sup = '{por: 1'b1, uv: 1'b1, ov: 1'b0, low_batt: 1'b0,
            double_batt: 1'b0, io_ok: 1'b1};
        void'($urandom(21924));
        tick(12);
        rstn = 1'b1;
        tick(4);
        check(miso_oe_n, 1'b1);
        sup.por = 1'b0;
        host.send(24'hf00000);
        check(nwords, 0);
        check(miso_oe_n, 1'b1);
        check(cfg.current_code, 3'h0);
        sup.uv = 1'b0;
        n = 0;
        bad = 1'b0;
        while (ready !== 1'b1 && n < `SSL_READY_MAX_CYC + 100) begin
            if (int_n !== 1'b0) bad = 1'b1;
            tick(1);
            n++;
        end
        check(bad, 1'b0);
        bad = (n < `SSL_READY_CYC) || (n > `SSL_READY_MAX_CYC);
        check(bad, 1'b0);
        check(int_n, 1'b1);
        check(32'(cfg), exp_cfg(3'h0, 1'b1, 1'b1));
        host.send(24'h000000);
        check(host.rx[23:19], exp_cfg(3'h0, 1'b1, 1'b1));
        for (int k = 0; k < 3; k++) begin
            code = 3'($urandom_range(7, 1));
            sup.low_batt = (k == 1);
            sup.double_batt = (k == 2);
            w = {1'b1, code, 18'($urandom), 2'b11};
            fork
                host.send(w);
                begin
                    tick(10);
                    check(miso_oe_n, 1'b0);
                end
            join
            check(wdata, w);
            check(32'(cfg), exp_cfg(code, 1'b0, 1'b0));
            check(cur, code);
        end
        check(nwords, 4);
        sup.ov = 1'b1;
        tick(5);
        check(cur, `SSL_CURLIM_CODE);
        check(cfg.current_code, code);
        sup.ov = 1'b0;
        tick(5);
        check(cur, code);
        ev = 1'b1;
        tick(2);
        check(int_n, 1'b0);
        ev = 1'b0;
        sup.io_ok = 1'b0;
        tick(2);
        check(miso_oe_n, 1'b1);
        n0 = nwords;
        host.send({1'b1, ~code, 20'h3});
        check(nwords, n0);
        check(32'(cfg), exp_cfg(code, 1'b0, 1'b0));
        check(ready, 1'b1);
        sup.io_ok = 1'b1;
        host.send(24'h000000);
        check(host.rx[23:19], {code, 2'b00});
        n0 = nwords;
        fork
            host.send({1'b1, ~code, 20'h0});
            begin
                tick(30);
                sup.uv = 1'b1;
            end
        join
        tick(4);
        check(nwords, n0);
        check(cfg.current_code, code);
        check(cfg.uv_seen, 1'b1);
        check(miso_oe_n, 1'b1);
        check(ready, 1'b0);
        tally_and_finish();
    end
endmodule
